// [board_model.sv]
// board around the block: pull resistors on the shared pins, the link
// strap resistor and the 20 MHz oscillator
// assumes pin enables are low while the block drives the pin
`timescale 1ns/1ns
module board_model (
   // pins of the block
   input wire logic mdio_pin_o,
   input wire logic mdio_pin_oe_n_o,
   input wire logic int_pin_o,
   input wire logic int_pin_oe_n_o,
   input wire logic link1_pin_o,
   input wire logic link1_pin_oe_n_o,
   // host and strap side
   input wire logic host_drive_i,
   input wire logic host_data_i,
   input wire logic link1_strap_i,
   // resolved levels
   output logic ref_clock_o,
   output logic mdio_wire_o,
   output logic int_wire_o,
   output logic link1_wire_o
);
   ////////////////////////////////////////////////////////////////////////
   // oscillator runs free, unrelated in phase to the system clock
   // offset so its edges never share a time step with a system clock edge
   initial begin
      ref_clock_o = 1'b0;
      #2;
      forever #25 ref_clock_o = ~ref_clock_o;
   end
   ////////////////////////////////////////////////////////////////////////
   // a released pin falls back to its resistor, or on mdio to the host while it drives, never to the last value
   assign mdio_wire_o = !mdio_pin_oe_n_o ? mdio_pin_o : (host_drive_i ? host_data_i : 1'b1);
   assign int_wire_o = !int_pin_oe_n_o ? int_pin_o : 1'b1;
   assign link1_wire_o = !link1_pin_oe_n_o ? link1_pin_o : link1_strap_i;
endmodule : board_model

// [led_serializer.sv]
// serial led shifter: shifts a status frame out with its own shift clock
// assumes the frame word is stable for a whole frame; it is latched at start
`timescale 1ns/1ns
module led_serializer
   import strap_pins_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // control
   input wire logic enable_i,
   input wire logic [7:0] half_period_i,
   input wire logic [LED_FRAME_BITS-1:0] frame_i,
   // pins
   output logic led_shift_clock_o,
   output logic led_serial_out_o
);
   logic [7:0] div_count;
   logic [4:0] bit_index;
   logic [LED_FRAME_BITS-1:0] shift_word;
   wire half_done = (div_count >= half_period_i);
   wire falling_now = half_done & led_shift_clock_o;

   // divider and shifter; data changes on the falling edge so the
   // external registers see it settled at the rising edge
   always_ff @(posedge clock_i) begin
      if (sys_rst_i | ~enable_i) begin
         div_count <= 8'h00;
         bit_index <= 5'h00;
         shift_word <= frame_i;
         led_shift_clock_o <= 1'b0;
         led_serial_out_o <= 1'b0;
      end else if (half_done) begin
         div_count <= 8'h00;
         led_shift_clock_o <= ~led_shift_clock_o;
         if (falling_now) begin
            led_serial_out_o <= shift_word[LED_FRAME_BITS-1];
            shift_word <= (bit_index == LED_FRAME_LAST) ? frame_i
               : {shift_word[LED_FRAME_BITS-2:0], 1'b0};
            bit_index <= (bit_index == LED_FRAME_LAST) ? 5'h00 : bit_index + 5'h01;
         end
      end else begin
         div_count <= div_count + 8'h01;
      end
   end
endmodule : led_serializer

// [quad_phy_status_strap_pins_tb_top.sv]
// self-checking bench for the strap and shared pin control block
// assumes one 100 MHz clock; board_model supplies pull-ups and oscillator
`timescale 1ns/1ns
module quad_phy_status_strap_pins_tb_top;
   import strap_pins_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rst_pin_n = 1'b1;
   logic strap_mgmt = 1'b1;
   logic [3:0] dup = 4'h5;
   logic [3:0] lost = 4'h0;
   logic [3:0] jab = 4'h0;
   logic md_out = 1'b0;
   logic md_drv = 1'b0;
   logic ack = 1'b0;
   logic host_drv = 1'b0;
   logic host_dat = 1'b0;
   logic l1_strap = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic mdio_o, mdio_oe, int_o, int_oe, l1_o, l1_oe, l2_o, ledc, ledd;
   logic md_in, dev_rst, mgmt_en, idle_hi, wreq, irq, refclk, mdio_w, int_w, l1_w;
   logic [3:0] fdx;
   logic [31:0] rdat;
   int err_total = 0;
   int checked = 0;
   int n;
   logic seen;
   logic [15:0] led_sr = 16'h0000;
   always #5 clock_i = ~clock_i;
   // external led shift register, takes data on the rising shift clock
   always @(posedge ledc) led_sr <= {led_sr[14:0], ledd};
   ////////////////////////////////////////////////////////////////////////
   strap_pin_control dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .reset_pin_n_i(rst_pin_n), .ref_clock_in_i(refclk), .mgmt_strap_i(strap_mgmt),
      .port_duplex_select_i(dup), .mdio_pin_i(mdio_w), .mdio_pin_o(mdio_o),
      .mdio_pin_oe_n_o(mdio_oe), .int_pin_o(int_o), .int_pin_oe_n_o(int_oe),
      .link1_pin_i(l1_w), .link1_pin_o(l1_o), .link1_pin_oe_n_o(l1_oe),
      .link2_pin_o(l2_o), .led_shift_clock_o(ledc), .led_serial_out_o(ledd),
      .link_lost_i(lost), .jabber_i(jab), .mgmt_data_out_i(md_out),
      .mgmt_data_drive_i(md_drv), .mgmt_ack_i(ack), .mgmt_data_in_o(md_in),
      .device_reset_o(dev_rst), .mgmt_enabled_o(mgmt_en), .rxd_idle_high_o(idle_hi),
      .full_duplex_o(fdx), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .irq_o(irq));
   board_model board (.mdio_pin_o(mdio_o), .mdio_pin_oe_n_o(mdio_oe), .int_pin_o(int_o),
      .int_pin_oe_n_o(int_oe), .link1_pin_o(l1_o), .link1_pin_oe_n_o(l1_oe),
      .host_drive_i(host_drv), .host_data_i(host_dat), .link1_strap_i(l1_strap),
      .ref_clock_o(refclk), .mdio_wire_o(mdio_w), .int_wire_o(int_w), .link1_wire_o(l1_w));
   ////////////////////////////////////////////////////////////////////////
   // closing report, the only place the run ends
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic tick(input int c);
      repeat (c) @(posedge clock_i);
   endtask : tick
   // one avalon transfer; entered just after an edge, leaves one idle cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int g;
      g = 0;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clock_i);
         g++;
      end while (wreq !== 1'b0 && g < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (g >= 50) begin
         err_total++;
         wrap_up();
      end
      @(posedge clock_i);
   endtask : bus
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, d_zero(), q);
      check($sformatf("reg %h", a), exp, q);
   endtask : rd_chk
   function automatic logic [31:0] d_zero();
      return 32'h0;
   endfunction : d_zero
   // pin reset pulse of a given length in clocks; notes if the device reset
   task automatic pin_reset(input int c);
      int g;
      seen = 1'b0;
      rst_pin_n <= 1'b0;
      for (g = 0; g < c + 30; g++) begin
         @(posedge clock_i);
         if (g == c) rst_pin_n <= 1'b1;
         if (dev_rst === 1'b1) seen = 1'b1;
      end
   endtask : pin_reset
   // clocks between two toggles of the led shift clock
   task automatic led_half(output int h);
      logic last;
      int g;
      g = 0;
      h = 0;
      last = ledc;
      while (ledc === last && g < 600) begin
         @(posedge clock_i);
         g++;
      end
      last = ledc;
      while (ledc === last && g < 600) begin
         @(posedge clock_i);
         g++;
         h++;
      end
      if (g >= 600) begin
         err_total++;
         wrap_up();
      end
   endtask : led_half
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #900000;
      err_total++;
      wrap_up();
   end
   // main sequence
   initial begin
      tick(8);
      sys_rst_i <= 1'b0;
      tick(2);
      check("mgmt enabled", 1'b1, mgmt_en);
      check("idle high", 1'b1, idle_hi);
      check("full duplex", 4'hA, fdx);
      rd_chk(REG_MASK, {24'h0, MASK_RESET});
      rd_chk(REG_LED_CTRL, 32'h104);
      rd_chk(8'h40, 32'h0);
      wr_reg(REG_LINK, 32'hFF);
      rd_chk(REG_LINK, 32'hA0);
      // 25 reference clocks is too short and must not reach the straps
      dup <= 4'h3;
      l1_strap <= 1'b1;
      pin_reset(125);
      check("short pulse", 1'b0, seen);
      check("straps kept", 4'hA, fdx);
      pin_reset(200);
      check("long pulse", 1'b1, seen);
      check("straps new", 4'hC, fdx);
      check("idle low", 1'b0, idle_hi);
      dup <= 4'h0;
      tick(8);
      check("no live duplex", 4'hC, fdx);
      // link loss on ports 1 and 2
      lost <= 4'h3;
      tick(4);
      check("link1 pin", 1'b1, l1_w);
      check("link2 pin", 1'b1, l2_o);
      check("int pin low", 1'b0, int_w);
      rd_chk(REG_STATUS, 32'h03);
      check("irq masked", 1'b0, irq);
      wr_reg(REG_MASK, 32'h01);
      check("irq raised", 1'b1, irq);
      jab <= 4'h8;
      tick(2);
      rd_chk(REG_STATUS, 32'h83);
      wr_reg(REG_STATUS, 32'h01);
      rd_chk(REG_STATUS, 32'h82);
      check("irq cleared", 1'b0, irq);
      check("int held", 1'b0, int_w);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(3);
      check("int released", 1'b1, int_w);
      // management data pin both ways
      md_drv <= 1'b1;
      tick(3);
      check("mdio driven", 1'b0, mdio_w);
      md_drv <= 1'b0;
      host_drv <= 1'b1;
      tick(6);
      check("mdio released", 1'b1, mdio_oe);
      check("mdio in low", 1'b0, md_in);
      host_dat <= 1'b1;
      tick(6);
      check("mdio in high", 1'b1, md_in);
      host_drv <= 1'b0;
      // led shift clock rate follows the divider
      led_half(n);
      check("led half", 32'(LED_DIV_RESET) + 1, n);
      wr_reg(REG_LED_CTRL, 32'h101);
      tick(20);
      led_half(n);
      check("led half fast", 32'h2, n);
      // enhanced mode: shared pins carry ports 4 and 3 link loss
      strap_mgmt <= 1'b0;
      pin_reset(200);
      check("mgmt disabled", 1'b0, mgmt_en);
      lost <= 4'h8;
      tick(4);
      check("mdio port4", 1'b1, mdio_w);
      check("mdio drive", 1'b0, mdio_oe);
      check("int port3", 1'b0, int_w);
      lost <= 4'h4;
      tick(4);
      check("mdio port4 ok", 1'b0, mdio_w);
      check("int port3 lost", 1'b1, int_w);
      dup <= 4'h6;
      tick(8);
      check("live duplex", 4'h9, fdx);
      // frame {lost 4, jabber 8, full duplex 9, status F} has eight ones in any rotation
      tick(140);
      check("led ones", 32'h8, $countones(led_sr));
      wrap_up();
   end
endmodule : quad_phy_status_strap_pins_tb_top

// [strap_pin_control.sv]
// pin level control: reset filter, strap capture, shared management pins,
// link lost outputs, led serial port and an avalon register slave
// assumes core signals (link, jabber, management engine) are on clock_i
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module strap_pin_control
   import strap_pins_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // asynchronous pins
   input wire logic reset_pin_n_i,
   input wire logic ref_clock_in_i,
   input wire logic mgmt_strap_i,
   input wire logic [3:0] port_duplex_select_i,
   // management data pin
   input wire logic mdio_pin_i,
   output logic mdio_pin_o,
   output logic mdio_pin_oe_n_o,
   // interrupt pin
   output logic int_pin_o,
   output logic int_pin_oe_n_o,
   // link lost pins
   input wire logic link1_pin_i,
   output logic link1_pin_o,
   output logic link1_pin_oe_n_o,
   output logic link2_pin_o,
   // led pins
   output logic led_shift_clock_o,
   output logic led_serial_out_o,
   // core side
   input wire logic [3:0] link_lost_i,
   input wire logic [3:0] jabber_i,
   input wire logic mgmt_data_out_i,
   input wire logic mgmt_data_drive_i,
   input wire logic mgmt_ack_i,
   output logic mgmt_data_in_o,
   output logic device_reset_o,
   output logic mgmt_enabled_o,
   output logic rxd_idle_high_o,
   output logic [3:0] full_duplex_o,
   // avalon slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_COUNT-1:0] sync1, sync2, sync3, pins;
   wire [PIN_COUNT-1:0] raw_pins = {port_duplex_select_i, mdio_pin_i, link1_pin_i,
      mgmt_strap_i, ref_clock_in_i, reset_pin_n_i};

   // a pin changes only once the last two stages agree
   function automatic logic [PIN_COUNT-1:0] agree(input logic [PIN_COUNT-1:0] a,
      input logic [PIN_COUNT-1:0] b, input logic [PIN_COUNT-1:0] held);
      agree = (a & b) | (held & (a | b));
   endfunction : agree

   // sync1 is read by sync2 only
   always_ff @(posedge clock_i) begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   // agreed pin levels; during system reset they load the last stage so
   // the straps caught in reset see the real pin levels, not defaults
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pins <= sync3;
      end else begin
         pins <= agree(sync2, sync3, pins);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset pin noise filter counted in reference clock edges

   logic ref_prev;
   logic [5:0] low_count;
   logic pin_reset;
   wire ref_rise = pins[PIN_REF_CLK] & ~ref_prev;
   wire rst_low = ~pins[PIN_RST_N];
   wire filter_done = (low_count > RST_FILTER_COUNT);
   wire [5:0] next_low_count = (~rst_low) ? 6'h00
      : (ref_rise & ~filter_done) ? low_count + 6'h01 : low_count;

   // short pulses never reach the count and are dropped
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ref_prev <= 1'b0;
         low_count <= 6'h00;
         pin_reset <= 1'b0;
      end else begin
         ref_prev <= pins[PIN_REF_CLK];
         low_count <= next_low_count;
         pin_reset <= rst_low & (filter_done | pin_reset);
      end
   end

   wire in_reset = sys_rst_i | pin_reset;
   assign device_reset_o = in_reset;

   ////////////////////////////////////////////////////////////////////////
   // strap capture; straps track the pins for as long as reset holds

   logic mgmt_en;
   logic link1_strap;
   logic [3:0] duplex_strap;
   logic [3:0] duplex_live;

   always_ff @(posedge clock_i) begin
      if (in_reset) begin
         mgmt_en <= pins[PIN_MGMT_STRAP];
         link1_strap <= pins[PIN_LINK1];
         duplex_strap <= pins[PIN_DUPLEX +: 4];
      end
   end

   // enhanced full duplex follows the pins after reset
   always_ff @(posedge clock_i) begin
      if (in_reset) begin
         duplex_live <= pins[PIN_DUPLEX +: 4];
      end else if (~mgmt_en) begin
         duplex_live <= pins[PIN_DUPLEX +: 4];
      end
   end

   wire [3:0] duplex_level = mgmt_en ? duplex_strap : duplex_live;
   assign full_duplex_o = ~duplex_level;
   assign mgmt_enabled_o = mgmt_en;
   assign rxd_idle_high_o = ~link1_strap;
   assign mgmt_data_in_o = pins[PIN_MDIO];

   ////////////////////////////////////////////////////////////////////////
   // events and interrupt state

   logic [3:0] link_prev, jabber_prev;
   logic [7:0] status, mask;
   logic int_pending;
   logic [7:0] led_div;
   logic led_en;
   wire [3:0] link_change = link_lost_i ^ link_prev;
   wire [3:0] jabber_rise = jabber_i & ~jabber_prev;
   wire [7:0] events = {jabber_rise, link_change};
   wire any_event = |events;

   // avalon handshake: one wait cycle, answer in the second
   logic bus_ack;
   wire bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~bus_ack;
   wire wr_take = avs_write & bus_ack;
   wire wr_status = wr_take & (avs_address == REG_STATUS);
   wire wr_mask = wr_take & (avs_address == REG_MASK);
   wire wr_led = wr_take & (avs_address == REG_LED_CTRL);
   wire [7:0] status_clear = wr_status ? avs_writedata[7:0] : 8'h00;
   // set wins over a clear in the same cycle
   wire [7:0] next_status = (status & ~status_clear) | events;
   assign irq_o = |(status & mask);

   always_ff @(posedge clock_i) begin
      if (in_reset) begin
         link_prev <= link_lost_i;
         jabber_prev <= jabber_i;
         status <= 8'h00;
         int_pending <= 1'b0;
      end else begin
         link_prev <= link_lost_i;
         jabber_prev <= jabber_i;
         status <= next_status;
         int_pending <= any_event | (int_pending & ~mgmt_ack_i);
      end
   end

   // software controls clear only on the system reset and survive a pin reset
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mask <= MASK_RESET;
         led_div <= LED_DIV_RESET;
         led_en <= 1'b1;
      end else begin
         if (wr_mask) begin
            mask <= avs_writedata[7:0];
         end
         if (wr_led) begin
            led_div <= avs_writedata[7:0];
            led_en <= avs_writedata[8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read path

   wire [31:0] rd_mux =
      (avs_address == REG_STATUS) ? {24'h000000, status} :
      (avs_address == REG_MASK) ? {24'h000000, mask} :
      (avs_address == REG_STRAP) ? {25'h0000000, int_pending, link1_strap, mgmt_en,
         duplex_strap} :
      (avs_address == REG_LINK) ? {24'h000000, full_duplex_o, link_lost_i} :
      (avs_address == REG_LED_CTRL) ? {23'h000000, led_en, led_div} : 32'h00000000;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         avs_readdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared pin drivers; registered so the pins never glitch

   always_ff @(posedge clock_i) begin
      if (in_reset) begin
         mdio_pin_o <= 1'b0;
         mdio_pin_oe_n_o <= 1'b1;
         int_pin_o <= 1'b0;
         int_pin_oe_n_o <= 1'b1;
         link1_pin_o <= 1'b0;
         link1_pin_oe_n_o <= 1'b1; // released so the strap can be read
         link2_pin_o <= 1'b0;
      end else begin
         if (mgmt_en) begin
            mdio_pin_o <= mgmt_data_out_i;
            mdio_pin_oe_n_o <= ~mgmt_data_drive_i;
            int_pin_o <= 1'b0;
            int_pin_oe_n_o <= ~int_pending;
         end else begin
            mdio_pin_o <= link_lost_i[3];
            mdio_pin_oe_n_o <= 1'b0;
            int_pin_o <= link_lost_i[2];
            int_pin_oe_n_o <= 1'b0;
         end
         link1_pin_o <= link_lost_i[0];
         link1_pin_oe_n_o <= 1'b0;
         link2_pin_o <= link_lost_i[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial led port

   led_serializer led_port (
      .clock_i(clock_i),
      .sys_rst_i(in_reset),
      .enable_i(led_en),
      .half_period_i(led_div),
      .frame_i({link_lost_i, jabber_i, full_duplex_o, status[3:0]}),
      .led_shift_clock_o(led_shift_clock_o),
      .led_serial_out_o(led_serial_out_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // assertions

   mdio_link4_a: assert property (@(posedge clock_i) disable iff (in_reset)
      ~mgmt_en & ~$past(in_reset) |-> mdio_pin_o == $past(link_lost_i[3]) && !mdio_pin_oe_n_o)
      else $error("data pin does not show port 4 link lost");

   int_link3_a: assert property (@(posedge clock_i) disable iff (in_reset)
      ~mgmt_en & ~$past(in_reset) |-> int_pin_o == $past(link_lost_i[2]) && !int_pin_oe_n_o)
      else $error("interrupt pin does not show port 3 link lost");

   int_drive_a: assert property (@(posedge clock_i) disable iff (in_reset)
      mgmt_en & any_event |=> ##1 (!int_pin_oe_n_o && !int_pin_o))
      else $error("interrupt pin not pulled low after event");

   int_hold_a: assert property (@(posedge clock_i) disable iff (in_reset)
      int_pending & ~mgmt_ack_i |=> int_pending)
      else $error("pending interrupt dropped without acknowledge");

   event_set_a: assert property (@(posedge clock_i) disable iff (in_reset)
      $changed(link_lost_i) & ~$past(in_reset) |-> ##1 (status[3:0] != 4'h0 && int_pending))
      else $error("link change raised no event");

   link12_a: assert property (@(posedge clock_i) disable iff (in_reset)
      ~$past(in_reset) |-> link2_pin_o == $past(link_lost_i[1])
      && link1_pin_o == $past(link_lost_i[0]))
      else $error("port 1 or 2 link output wrong");

   short_reset_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      pin_reset |-> low_count > RST_FILTER_COUNT && $past(rst_low))
      else $error("device reset without a long enough pin reset");

   straps_held_a: assert property (@(posedge clock_i) disable iff (in_reset)
      ~$past(in_reset) |-> $stable(duplex_strap) && $stable(link1_strap) && $stable(mgmt_en))
      else $error("straps changed outside reset");

   idle_level_a: assert property (@(posedge clock_i)
      pin_reset |=> rxd_idle_high_o == !$past(pins[PIN_LINK1]))
      else $error("idle level does not follow strap");

   duplex_live_a: assert property (@(posedge clock_i) disable iff (in_reset)
      ~mgmt_en |=> duplex_live == $past(pins[PIN_DUPLEX +: 4]))
      else $error("enhanced duplex not following pins");

   mgmt_strap_a: assert property (@(posedge clock_i)
      pin_reset |=> mgmt_en == $past(pins[PIN_MGMT_STRAP]))
      else $error("management strap not caught in reset");

endmodule : strap_pin_control

// [strap_pins_pkg.sv]
// constants shared by the strap and pin control logic
// assumes a single 100 MHz system clock and byte addressed avalon registers
package strap_pins_pkg;
   // clock and reset filter timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_CLK_MHZ = 20;
   localparam int RST_FILTER_REF_CYCLES = 30;
   localparam logic [5:0] RST_FILTER_COUNT = 6'(RST_FILTER_REF_CYCLES);
   // synchronised pin vector layout
   localparam int PIN_RST_N = 0;
   localparam int PIN_REF_CLK = 1;
   localparam int PIN_MGMT_STRAP = 2;
   localparam int PIN_LINK1 = 3;
   localparam int PIN_MDIO = 4;
   localparam int PIN_DUPLEX = 5;
   localparam int PIN_COUNT = 9;
   // register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_MASK = 8'h04;
   localparam logic [7:0] REG_STRAP = 8'h08;
   localparam logic [7:0] REG_LINK = 8'h0C;
   localparam logic [7:0] REG_LED_CTRL = 8'h10;
   // reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] LED_DIV_RESET = 8'h04;
   localparam logic [3:0] DUPLEX_RESET = 4'hF;
   // led frame
   localparam int LED_FRAME_BITS = 16;
   localparam logic [4:0] LED_FRAME_LAST = 5'h0F;
endpackage : strap_pins_pkg
